// file: core/idmap_consts.svh
// Function
// - Route device interrupts onto 13 system IRQ lines by configuration.
// - Each device takes its IRQ and DMA choice from its own registers.
// - Bit 1 of interrupt type register 71h selects polarity and drive type.
// - High polarity is push-pull; low is open-drain, strong then weak pull-up.
// - Polarity affects only output buffers, not keyboard or parallel inputs.
// - Float an IRQ line if unmapped, owner inactive or owner floating.
// - Float DRQ, hold device acknowledge at 1 if unmapped, inactive, floating.
`ifndef IDMAP_CONSTS_SVH
`define IDMAP_CONSTS_SVH

`define IDM_NDEV          6
`define IDM_NLINE         13
`define IDM_NCHAN         4
// Register indexes within each device's configuration space
`define IDM_IDX_ACTIVATE  8'h30
`define IDM_IDX_IRQ_SEL   8'h70
`define IDM_IDX_IRQ_TYPE  8'h71
`define IDM_IDX_DMA_SEL   8'h74
// Status space, reached through spare device number 7
`define IDM_STAT_DEV      3'h7
`define IDM_IDX_STAT_LO   8'h00
`define IDM_IDX_STAT_HI   8'h01
`define IDM_IDX_STAT_DMA  8'h02
// Field positions
`define IDM_ACT_BIT       0
`define IDM_POL_BIT       1
// Reset values
`define IDM_RST_ACTIVATE  8'h00
`define IDM_RST_IRQ_SEL   8'h00
`define IDM_RST_IRQ_TYPE  8'h02
`define IDM_RST_DMA_SEL   8'h04
`define IDM_DMA_NONE      3'h4
// System IRQ numbers served by lines 0..12, in line order
`define IDM_LINE_NUMS     '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, \
                            4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf}
// Strong pull-up time after an open-drain release
`define IDM_CLK_NS        100
`define IDM_STRONG_NS     100
`define IDM_STRONG_CYC    (((`IDM_STRONG_NS + `IDM_CLK_NS - 1) / `IDM_CLK_NS) \
                           < 1 ? 1 : \
                           ((`IDM_STRONG_NS + `IDM_CLK_NS - 1) / `IDM_CLK_NS))

`endif

// file: core/idmap_pkg.sv
`default_nettype none
`include "idmap_consts.svh"
package idmap_pkg;
	typedef logic [2:0] idmap_dev_t;
	typedef logic [7:0] idmap_byte_t;
	typedef logic [3:0] idmap_cnt_t;
	typedef enum logic [1:0] {
		IDMAP_OFF,
		IDMAP_ASSERT,
		IDMAP_STRONG,
		IDMAP_WEAK
	} idmap_drv_e;
endpackage
`default_nettype wire

// file: core/idmap_irq_drv.sv
`timescale 1ns/1ps
`default_nettype none
`include "idmap_consts.svh"
module idmap_irq_drv
	import idmap_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	input  wire logic claimed_i,
	input  wire logic req_i,
	input  wire logic low_pol_i,
	output logic      pin_o,
	output logic      pin_oe_o,
	output logic      weak_pu_o
);
	localparam idmap_cnt_t STRONG = idmap_cnt_t'(`IDM_STRONG_CYC);

	idmap_drv_e st_q;
	idmap_drv_e st_d;
	idmap_cnt_t cnt_q;

	// Open-drain sequencing: assert low, brief strong high, then weak
	always_comb begin
		st_d = st_q;
		case (st_q)
			IDMAP_OFF: begin
				if (claimed_i && low_pol_i)
					st_d = req_i ? IDMAP_ASSERT : IDMAP_WEAK;
			end
			IDMAP_ASSERT: begin
				if (!claimed_i || !low_pol_i)
					st_d = IDMAP_OFF;
				else if (!req_i)
					st_d = IDMAP_STRONG;
			end
			IDMAP_STRONG: begin
				if (!claimed_i || !low_pol_i)
					st_d = IDMAP_OFF;
				else if (req_i)
					st_d = IDMAP_ASSERT;
				else if (cnt_q == idmap_cnt_t'(1))
					st_d = IDMAP_WEAK;
			end
			IDMAP_WEAK: begin
				if (!claimed_i || !low_pol_i)
					st_d = IDMAP_OFF;
				else if (req_i)
					st_d = IDMAP_ASSERT;
			end
			default: st_d = IDMAP_OFF;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			st_q <= IDMAP_OFF;
		else
			st_q <= st_d;
	end

	// Strong pull-up timer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cnt_q <= '0;
		else if (st_d == IDMAP_STRONG && st_q != IDMAP_STRONG)
			cnt_q <= STRONG;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - idmap_cnt_t'(1);
	end

	// Registered pin drive; push-pull when high polarity
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o     <= 1'b0;
			pin_oe_o  <= 1'b0;
			weak_pu_o <= 1'b0;
		end else if (!claimed_i) begin
			pin_o     <= 1'b0;
			pin_oe_o  <= 1'b0;
			weak_pu_o <= 1'b0;
		end else if (!low_pol_i) begin
			pin_o     <= req_i;
			pin_oe_o  <= 1'b1;
			weak_pu_o <= 1'b0;
		end else begin
			pin_o     <= (st_d == IDMAP_STRONG);
			pin_oe_o  <= (st_d == IDMAP_ASSERT) || (st_d == IDMAP_STRONG);
			weak_pu_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: core/idmap_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "idmap_consts.svh"
module idmap_top
	import idmap_pkg::*;
(
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	// Register port: address is {device, index}
	input  wire logic [10:0]            reg_addr_i,
	input  wire logic [7:0]             reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [7:0]             reg_rdata_o,
	// Logical device side
	input  wire logic [`IDM_NDEV-1:0]   dev_irq_i,
	input  wire logic [`IDM_NDEV-1:0]   dev_irq_float_i,
	input  wire logic [`IDM_NDEV-1:0]   dev_drq_i,
	input  wire logic [`IDM_NDEV-1:0]   dev_drq_float_i,
	output logic      [`IDM_NDEV-1:0]   dev_dack_n_o,
	// System IRQ lines
	output logic      [`IDM_NLINE-1:0]  irq_o,
	output logic      [`IDM_NLINE-1:0]  irq_oe_o,
	output logic      [`IDM_NLINE-1:0]  irq_weak_pu_o,
	// DMA channels
	output logic      [`IDM_NCHAN-1:0]  drq_o,
	output logic      [`IDM_NCHAN-1:0]  drq_oe_o,
	input  wire logic [`IDM_NCHAN-1:0]  dack_n_i
);
	localparam logic [3:0] LINE_NUM [`IDM_NLINE] = `IDM_LINE_NUMS;
	localparam int ND = `IDM_NDEV;
	localparam int NL = `IDM_NLINE;
	localparam int NC = `IDM_NCHAN;

	idmap_byte_t act_q      [ND];
	idmap_byte_t irq_sel_q  [ND];
	idmap_byte_t irq_type_q [ND];
	idmap_byte_t dma_sel_q  [ND];

	idmap_dev_t  dev_sel;
	idmap_byte_t idx_sel;
	logic [ND-1:0] dev_live;
	logic [NL-1:0] line_claim;
	logic [NL-1:0] line_req;
	logic [NL-1:0] line_low;
	logic [NC-1:0] chan_claim;
	logic [NC-1:0] chan_req;
	logic [NC-1:0] dev_dack_ok [ND];
	logic [NC-1:0] drq_oe_q;
	logic [NC-1:0] drq_q;
	logic          idx_act;
	logic          idx_irq_sel;
	logic          idx_irq_type;
	logic          idx_dma_sel;
	logic          stat_hit;
	logic          dev_ok;
	idmap_byte_t   stat_lo;
	idmap_byte_t   stat_hi;
	idmap_byte_t   stat_dma;
	idmap_byte_t   reg_rdata_d;

	assign dev_sel = reg_addr_i[10:8];
	assign idx_sel = reg_addr_i[7:0];

	// Register index decode, shared by every device's writes; status and device range decode for the read path
	assign idx_act      = (idx_sel == `IDM_IDX_ACTIVATE);
	assign idx_irq_sel  = (idx_sel == `IDM_IDX_IRQ_SEL);
	assign idx_irq_type = (idx_sel == `IDM_IDX_IRQ_TYPE);
	assign idx_dma_sel  = (idx_sel == `IDM_IDX_DMA_SEL);
	assign stat_hit     = (dev_sel == `IDM_STAT_DEV);
	assign dev_ok       = (dev_sel < idmap_dev_t'(ND));

	// Per-device configuration registers
	genvar d;
	generate
		for (d = 0; d < ND; d++) begin : g_dev
			logic hit;
			assign hit = reg_wr_i && (dev_sel == idmap_dev_t'(d));

			// Activation; bit 0 makes the device live
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					act_q[d] <= `IDM_RST_ACTIVATE;
				else if (hit && idx_act)
					act_q[d] <= reg_wdata_i;
			end

			// Interrupt line select
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					irq_sel_q[d] <= `IDM_RST_IRQ_SEL;
				else if (hit && idx_irq_sel)
					irq_sel_q[d] <= reg_wdata_i;
			end

			// Interrupt type; bit 1 picks polarity and drive
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					irq_type_q[d] <= `IDM_RST_IRQ_TYPE;
				else if (hit && idx_irq_type)
					irq_type_q[d] <= reg_wdata_i;
			end

			// DMA channel select
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i)
					dma_sel_q[d] <= `IDM_RST_DMA_SEL;
				else if (hit && idx_dma_sel)
					dma_sel_q[d] <= reg_wdata_i;
			end

			assign dev_live[d] = act_q[d][`IDM_ACT_BIT];
		end
	endgenerate

	// IRQ line ownership; shared serial requests are ORed
	genvar l;
	generate
		for (l = 0; l < NL; l++) begin : g_line
			always_comb begin
				line_claim[l] = 1'b0;
				line_req[l]   = 1'b0;
				line_low[l]   = 1'b0;
				for (int k = 0; k < ND; k++) begin
					if (dev_live[k] && !dev_irq_float_i[k] &&
					    irq_sel_q[k][3:0] == LINE_NUM[l]) begin
						line_claim[l] = 1'b1;
						line_req[l]   = line_req[l] | dev_irq_i[k];
						line_low[l]   = line_low[l] |
						                !irq_type_q[k][`IDM_POL_BIT];
					end
				end
			end
			idmap_irq_drv u_drv (
				.sys_clk_i (sys_clk_i),
				.rst_n_i   (rst_n_i),
				.claimed_i (line_claim[l]),
				.req_i     (line_req[l]),
				.low_pol_i (line_low[l]),
				.pin_o     (irq_o[l]),
				.pin_oe_o  (irq_oe_o[l]),
				.weak_pu_o (irq_weak_pu_o[l])
			);
		end
	endgenerate

	// DMA channel ownership; software keeps owners unique
	genvar c;
	generate
		for (c = 0; c < NC; c++) begin : g_chan
			// A device owns the channel when live, driving and selecting it
			for (genvar m = 0; m < ND; m++) begin : g_own
				assign dev_dack_ok[m][c] = dev_live[m] &&
				                           !dev_drq_float_i[m] &&
				                           dma_sel_q[m][2:0] == 3'(c);
			end
			always_comb begin
				chan_claim[c] = 1'b0;
				chan_req[c]   = 1'b0;
				for (int k = 0; k < ND; k++) begin
					if (dev_dack_ok[k][c]) begin
						chan_claim[c] = 1'b1;
						chan_req[c]   = chan_req[c] | dev_drq_i[k];
					end
				end
			end
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					drq_q[c]    <= 1'b0;
					drq_oe_q[c] <= 1'b0;
				end else begin
					drq_q[c]    <= chan_claim[c] & chan_req[c];
					drq_oe_q[c] <= chan_claim[c];
				end
			end
		end
	endgenerate
	assign drq_o    = drq_q;
	assign drq_oe_o = drq_oe_q;

	// Acknowledge reaches a device only from its own live channel
	always_comb begin
		for (int k = 0; k < ND; k++) begin
			dev_dack_n_o[k] = 1'b1;
			for (int j = 0; j < NC; j++) begin
				if (dev_dack_ok[k][j])
					dev_dack_n_o[k] = dack_n_i[j];
			end
		end
	end

	// Status words: line drive enables, channel requests and enables
	assign stat_lo  = irq_oe_o[7:0];
	assign stat_hi  = {3'h0, irq_oe_o[NL-1:8]};
	assign stat_dma = {drq_q, drq_oe_q};

	// Read mux; no strobe or an unmapped address reads zero
	always_comb begin
		reg_rdata_d = 8'h00;
		if (reg_rd_i && stat_hit) begin
			case (idx_sel)
				`IDM_IDX_STAT_LO:  reg_rdata_d = stat_lo;
				`IDM_IDX_STAT_HI:  reg_rdata_d = stat_hi;
				`IDM_IDX_STAT_DMA: reg_rdata_d = stat_dma;
				default:           reg_rdata_d = 8'h00;
			endcase
		end else if (reg_rd_i && dev_ok) begin
			case (idx_sel)
				`IDM_IDX_ACTIVATE: reg_rdata_d = act_q[dev_sel];
				`IDM_IDX_IRQ_SEL:  reg_rdata_d = irq_sel_q[dev_sel];
				`IDM_IDX_IRQ_TYPE: reg_rdata_d = irq_type_q[dev_sel];
				`IDM_IDX_DMA_SEL:  reg_rdata_d = dma_sel_q[dev_sel];
				default:           reg_rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register, one cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else
			reg_rdata_o <= reg_rdata_d;
	end
endmodule
`default_nettype wire

// file: bench/idmap_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module idmap_chk (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic [10:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic [5:0]  dev_dack_n_o,
	input wire logic [12:0] irq_o,
	input wire logic [12:0] irq_oe_o,
	input wire logic [12:0] irq_weak_pu_o,
	input wire logic [3:0]  drq_o,
	input wire logic [3:0]  drq_oe_o,
	input wire logic [3:0]  dack_n_i
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Read strobe at one address
	sequence rd_at(logic [10:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	drq_float_a: assert property ((drq_o & ~drq_oe_o) == 4'h0)
		else $error("drq high undriven");
	dack_block_a: assert property (&dack_n_i |-> &dev_dack_n_o)
		else $error("ack without system ack");
	weak_release_a: assert property (
		($past(irq_oe_o) & ~irq_oe_o & irq_weak_pu_o & ~$past(irq_o)) == 13'h0)
		else $error("weak without strong high");
	strong_once_a: assert property (
		((irq_oe_o & irq_o & irq_weak_pu_o) &
		 $past(irq_oe_o & irq_o & irq_weak_pu_o)) == 13'h0)
		else $error("strong pull-up held too long");
	reset_quiet_a: assert property (disable iff (1'b0)
		!rst_n_i |-> irq_oe_o == 13'h0 && drq_oe_o == 4'h0 && &dev_dack_n_o)
		else $error("driven in reset");
	idle_read_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("data outside read slot");
	bad_dev_a: assert property (
		reg_rd_i && reg_addr_i[10:8] == 3'h6 |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	irq_stat_a: assert property (
		rd_at(11'h700) |=> reg_rdata_o == $past(irq_oe_o[7:0]))
		else $error("line status wrong");
	dma_stat_a: assert property (
		rd_at(11'h702) |=> reg_rdata_o == {$past(drq_o), $past(drq_oe_o)})
		else $error("channel status wrong");
endmodule
bind idmap_top idmap_chk u_chk (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.dev_dack_n_o(dev_dack_n_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
	.irq_weak_pu_o(irq_weak_pu_o), .drq_o(drq_o), .drq_oe_o(drq_oe_o),
	.dack_n_i(dack_n_i)
);
`default_nettype wire

// file: bench/idmap_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module idmap_sys_model (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       slow_i,
	input wire logic [3:0] drq_o,
	input wire logic [3:0] drq_oe_o,
	output logic     [3:0] dack_n_o
);
	logic [1:0] wait_q;
	// Grant only driven requests, at once or after three cycles
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q   <= 2'h0;
			dack_n_o <= 4'hf;
		end else if ((drq_o & drq_oe_o) == 4'h0) begin
			wait_q   <= 2'h0;
			dack_n_o <= 4'hf;
		end else if (slow_i && wait_q != 2'h3) begin
			wait_q <= wait_q + 2'h1;
		end else begin
			dack_n_o <= ~(drq_o & drq_oe_o);
		end
	end
endmodule
`default_nettype wire

// file: bench/irq_dma_channel_mapping_test.sv
`timescale 1ns/1ps
`default_nettype none
module irq_dma_channel_mapping_test;
	logic        clk = 1'b0;
	logic        rst_n = 1'b1;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        slow = 1'b0;
	logic [10:0] addr = 11'h0;
	logic [7:0]  wd = 8'h0;
	logic [5:0]  irq = 6'h0;
	logic [5:0]  ifl = 6'h0;
	logic [5:0]  drq = 6'h0;
	logic [5:0]  dfl = 6'h0;
	logic [7:0]  rdat;
	logic [5:0]  dackd;
	logic [12:0] io, ioe, iw;
	logic [3:0]  dq, dqe, dk;
	int          failures = 0;
	int          compares = 0;
	int          n;
	// IRQ numbers carried by lines 0..12
	logic [3:0]  nums [13] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
		4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf};
	idmap_top uut (
		.sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat),
		.dev_irq_i(irq), .dev_irq_float_i(ifl), .dev_drq_i(drq),
		.dev_drq_float_i(dfl), .dev_dack_n_o(dackd), .irq_o(io),
		.irq_oe_o(ioe), .irq_weak_pu_o(iw), .drq_o(dq), .drq_oe_o(dqe),
		.dack_n_i(dk)
	);
	idmap_sys_model sys (
		.sys_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .drq_o(dq),
		.drq_oe_o(dqe), .dack_n_o(dk)
	);
	// Clock
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic end_of_test;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] d, input logic [7:0] i, v);
		@(posedge clk);
		addr <= {d, i};
		wd <= v;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] d, input logic [7:0] i, e);
		@(posedge clk);
		addr <= {d, i};
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk({8'h0, rdat}, {8'h0, e});
	endtask
	// Main sequence
	initial begin
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdc(3'h0, 8'h30, 8'h00);
		rdc(3'h0, 8'h70, 8'h00);
		rdc(3'h5, 8'h71, 8'h02);
		rdc(3'h5, 8'h74, 8'h04);
		rdc(3'h6, 8'h70, 8'h00);
		wr(3'h7, 8'h00, 8'hff);
		rdc(3'h7, 8'h00, 8'h00);
		// One high polarity requester walked over all lines
		irq <= 6'h01;
		wr(3'h0, 8'h30, 8'h01);
		for (n = 0; n < 13; n++) begin
			wr(3'h0, 8'h70, {4'h0, nums[n]});
			cyc(2);
			chk({3'h0, ioe}, 16'h1 << n);
			chk({3'h0, io}, 16'h1 << n);
		end
		rdc(3'h7, 8'h01, 8'h10);
		// Low polarity: low, strong high, then weak pull-up
		wr(3'h0, 8'h71, 8'h00);
		wr(3'h0, 8'h70, 8'h03);
		cyc(2);
		chk({io[1], ioe[1], iw[1]}, 16'h3);
		irq <= 6'h00;
		cyc(1);
		chk({io[1], ioe[1]}, 16'h3);
		cyc(1);
		chk({ioe[1], iw[1]}, 16'h1);
		// Floating or inactive owner leaves the line undriven
		irq <= 6'h01;
		ifl <= 6'h01;
		cyc(2);
		chk({ioe[1], iw[1]}, 16'h0);
		ifl <= 6'h00;
		cyc(2);
		chk({io[1], ioe[1]}, 16'h1);
		wr(3'h0, 8'h30, 8'h00);
		cyc(2);
		chk({3'h0, ioe}, 16'h0);
		// Serial ports a and b (devices 1, 2) share one line
		for (n = 1; n < 3; n++) begin
			wr(n[2:0], 8'h30, 8'h01);
			wr(n[2:0], 8'h70, 8'h04);
		end
		for (n = 0; n < 4; n++) begin
			irq <= {3'h0, n[1:0], 1'b0};
			cyc(2);
			chk({io[2], ioe[2]}, (n != 0) ? 16'h3 : 16'h1);
		end
		// Device 4 over all channels, partner prompt and slow
		wr(3'h4, 8'h30, 8'h01);
		for (n = 0; n < 4; n++) begin
			drq <= 6'h00;
			slow <= n[0];
			wr(3'h4, 8'h74, {6'h0, n[1:0]});
			drq <= 6'h10;
			cyc(2);
			chk({12'h0, dqe}, 16'h1 << n);
			chk({12'h0, dq}, 16'h1 << n);
			for (int k = 0; k < 8 && dackd[4] !== 1'b0; k++)
				cyc(1);
			if (dackd[4] !== 1'b0) begin
				failures++;
				end_of_test();
			end
			chk({10'h0, dackd}, 16'h2f);
		end
		rdc(3'h7, 8'h02, 8'h88);
		dfl <= 6'h10;
		cyc(2);
		chk({6'h0, dqe, dackd}, 16'h3f);
		end_of_test();
	end
endmodule
`default_nettype wire
